// >>> core/ccpm_pkg.sv
// types shared by the ccp/pwm unit
// assumes ccpm_regs.svh for numeric constants
package ccpm_pkg;
    typedef enum logic [3:0] {
        CCPM_OFF = 4'h0, CCPM_RSVD = 4'h1, CCPM_CMP_TGL = 4'h2, CCPM_CAP_ANY = 4'h3,
        CCPM_CAP_FALL = 4'h4, CCPM_CAP_RISE = 4'h5, CCPM_CAP_R4 = 4'h6, CCPM_CAP_R16 = 4'h7,
        CCPM_CMP_SET = 4'h8, CCPM_CMP_CLR = 4'h9, CCPM_CMP_SW = 4'ha, CCPM_CMP_SPEC = 4'hb
    } ccpm_mode_t;
    typedef enum logic [1:0] {
        CCPM_SINGLE = 2'h0, CCPM_FWD = 2'h1, CCPM_HALF = 2'h2, CCPM_REV = 2'h3
    } ccpm_cfg_t;
    typedef struct packed {
        logic [7:0] tmr;
        logic [7:0] pr;
        logic [6:0] period_timer_control;
        logic [4:0] psc;
        logic [1:0] q;
        logic [7:0] u1_dl;
        logic [7:0] u1_dh;
        logic [7:0] u1_con;
        logic [1:0] u1_lat;
        logic [7:0] u2_dl;
        logic [7:0] u2_dh;
        logic [5:0] u2_con;
        logic [1:0] u2_lat;
        logic [7:0] as_ctl;
        logic [7:0] db_ctl;
        logic flag;
        logic raw1;
        logic raw2;
        logic [6:0] dead;
        logic cap_prev;
        logic [3:0] cap_cnt;
        logic cmp_prev;
        logic [3:0] prev_mode;
        logic [3:0] pin;
        logic [3:0] oe;
        logic u2_out;
        logic u2_oe;
        logic special;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ccpm_state_t;
endpackage

// >>> core/ccpm_regs.svh
// register offsets, field positions, reset values and prescale counts for the ccp/pwm unit
// assumes a 32-bit apb slave with one aligned word per register
`ifndef CCPM_REGS_SVH
`define CCPM_REGS_SVH
`define CCPM_TMR_OFF 8'h00
`define CCPM_PR_OFF 8'h04
`define CCPM_PERIOD_TIMER_CONTROL_OFF 8'h08
`define CCPM_U1_DL_OFF 8'h0c
`define CCPM_U1_DH_OFF 8'h10
`define CCPM_U1_CON_OFF 8'h14
`define CCPM_U2_DL_OFF 8'h18
`define CCPM_U2_DH_OFF 8'h1c
`define CCPM_U2_CON_OFF 8'h20
`define CCPM_AS_OFF 8'h24
`define CCPM_DB_OFF 8'h28
`define CCPM_STAT_OFF 8'h2c
`define CCPM_CON_RST 8'h00
`define CCPM_PR_RST 8'hff
`define CCPM_ZERO_RST 8'h00
`define CCPM_TMR_ON_BIT 2
`define CCPM_SD_STAT_BIT 7
`define CCPM_RESTART_BIT 7
`define CCPM_FLAG_BIT 0
`define CCPM_PSC_X1 5'h01
`define CCPM_PSC_X4 5'h04
`define CCPM_PSC_X16 5'h10
`define CCPM_CAP_X4 4'h3
`define CCPM_CAP_X16 4'hf
`endif

// >>> core/ccpm_top.sv
// capture/compare/pwm unit one (enhanced, up to four outputs) and pwm-only unit two (single output)
// assumes an apb master on pclk, synchronous pin inputs and an external capture timer value
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ccpm_regs.svh"
module ccpm_top import ccpm_pkg::*; #(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_in,
    input wire logic [15:0] capture_timer_val,
    input wire logic fault_in,
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic pwm_out_c,
    output logic pwm_out_d,
    output logic pwm_oe_a,
    output logic pwm_oe_b,
    output logic pwm_oe_c,
    output logic pwm_oe_d,
    output logic unit_two_out,
    output logic unit_two_oe,
    output logic unit_one_event_flag,
    output logic special_event_reset
);
    ccpm_state_t s_q, s_d;
    logic setup, wr, hit, tick, wrap, pwm1, pwm2, cmp_hit, cmp_rise, rise, fall, cap_ev, clr_flag, set_flag;
    logic [7:0] rd, wb;
    logic [4:0] psc_lim;
    logic [1:0] cfg;
    logic [3:0] lvl, en;
    logic [9:0] cnt_nx;

    assign setup = psel && !penable;
    assign wr = psel && penable && s_q.pready && pwrite;
    assign wb = pwdata[7:0];
    assign psc_lim = (s_q.period_timer_control[1:0] == 2'h0) ? `CCPM_PSC_X1 :
                     (s_q.period_timer_control[1:0] == 2'h1) ? `CCPM_PSC_X4 : `CCPM_PSC_X16;
    assign tick = s_q.period_timer_control[`CCPM_TMR_ON_BIT] && (s_q.psc == psc_lim - 5'h01);
    assign wrap = tick && (s_q.q == 2'h3) && (s_q.tmr == s_q.pr);
    // count that the next tick reaches, so the pin is low in the cycle the duty count is reached
    assign cnt_nx = {s_q.tmr, s_q.q} + 10'h001;
    assign pwm1 = (s_q.u1_con[3:2] == 2'h3);
    assign pwm2 = (s_q.u2_con[3:2] == 2'h3);
    assign cmp_hit = (capture_timer_val == {s_q.u1_dh, s_q.u1_dl});
    assign cmp_rise = cmp_hit && !s_q.cmp_prev;
    assign rise = capture_in && !s_q.cap_prev;
    assign fall = !capture_in && s_q.cap_prev;
    assign clr_flag = wr && (paddr == `CCPM_STAT_OFF) && pwdata[`CCPM_FLAG_BIT];

    // read mux and address decode
    always_comb begin
        hit = 1'b1;
        rd = 8'h00;
        case (paddr)
            `CCPM_TMR_OFF: rd = s_q.tmr;
            `CCPM_PR_OFF: rd = s_q.pr;
            `CCPM_PERIOD_TIMER_CONTROL_OFF: rd = {1'b0, s_q.period_timer_control};
            `CCPM_U1_DL_OFF: rd = s_q.u1_dl;
            `CCPM_U1_DH_OFF: rd = s_q.u1_dh;
            `CCPM_U1_CON_OFF: rd = s_q.u1_con;
            `CCPM_U2_DL_OFF: rd = s_q.u2_dl;
            `CCPM_U2_DH_OFF: rd = s_q.u2_dh;
            `CCPM_U2_CON_OFF: rd = {2'h0, s_q.u2_con};
            `CCPM_AS_OFF: rd = s_q.as_ctl;
            `CCPM_DB_OFF: rd = s_q.db_ctl;
            `CCPM_STAT_OFF: rd = {7'h00, s_q.flag};
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.special = 1'b0;
        set_flag = 1'b0;
        cap_ev = 1'b0;
        cfg = 2'h0;
        lvl = 4'h0;
        en = 4'h0;
        // apb slave: ready in the first access cycle
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !hit;
            s_d.prdata = {24'h000000, rd};
        end else if (psel && penable && s_q.pready) begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end
        // period timer with prescaler and 2-bit phase
        if (s_q.period_timer_control[`CCPM_TMR_ON_BIT]) begin
            s_d.psc = tick ? 5'h00 : s_q.psc + 5'h01;
            if (tick) begin
                s_d.q = s_q.q + 2'h1;
                if (s_q.q == 2'h3) begin
                    s_d.tmr = (s_q.tmr == s_q.pr) ? 8'h00 : s_q.tmr + 8'h01;
                end
            end
        end
        // unit one
        case (s_q.u1_con[3:0])
            CCPM_OFF, CCPM_RSVD: begin
                s_d.raw1 = 1'b0;
                s_d.cap_cnt = 4'h0;
                s_d.dead = 7'h00;
            end
            CCPM_CAP_ANY: cap_ev = rise || fall;
            CCPM_CAP_FALL: cap_ev = fall;
            CCPM_CAP_RISE: cap_ev = rise;
            CCPM_CAP_R4, CCPM_CAP_R16: begin
                if (rise) begin
                    s_d.cap_cnt = s_q.cap_cnt + 4'h1;
                    cap_ev = (s_q.cap_cnt == (s_q.u1_con[0] ? `CCPM_CAP_X16 : `CCPM_CAP_X4));
                    if (cap_ev) begin
                        s_d.cap_cnt = 4'h0;
                    end
                end
            end
            CCPM_CMP_TGL: begin
                if (cmp_rise) begin
                    s_d.raw1 = !s_q.raw1;
                    set_flag = 1'b1;
                end
            end
            CCPM_CMP_SET, CCPM_CMP_CLR: begin
                if (s_q.prev_mode != s_q.u1_con[3:0]) begin
                    s_d.raw1 = s_q.u1_con[0];
                end else if (cmp_rise) begin
                    s_d.raw1 = !s_q.u1_con[0];
                    set_flag = 1'b1;
                end
            end
            CCPM_CMP_SW: set_flag = cmp_rise;
            CCPM_CMP_SPEC: begin
                set_flag = cmp_rise;
                s_d.special = cmp_rise;
            end
            default: begin
                if (tick && wrap) begin
                    s_d.u1_dh = s_q.u1_dl;
                    s_d.u1_lat = s_q.u1_con[5:4];
                    s_d.raw1 = ({s_q.u1_dl, s_q.u1_con[5:4]} != 10'h000);
                    if (s_q.db_ctl[`CCPM_RESTART_BIT] && !fault_in) begin
                        s_d.as_ctl[`CCPM_SD_STAT_BIT] = 1'b0;
                    end
                end else if (tick && {s_q.u1_dh, s_q.u1_lat} == cnt_nx) begin
                    s_d.raw1 = 1'b0;
                end
                if (s_d.raw1 != s_q.raw1) begin
                    s_d.dead = s_q.db_ctl[6:0];
                end else if (s_q.dead != 7'h00) begin
                    s_d.dead = s_q.dead - 7'h01;
                end
            end
        endcase
        if (cap_ev) begin
            {s_d.u1_dh, s_d.u1_dl} = capture_timer_val;
            set_flag = 1'b1;
        end
        s_d.prev_mode = s_q.u1_con[3:0];
        s_d.cmp_prev = cmp_hit;
        s_d.cap_prev = capture_in;
        // unit two: single output pwm, no shutdown path
        if (pwm2 && wrap) begin
            s_d.u2_dh = s_q.u2_dl;
            s_d.u2_lat = s_q.u2_con[5:4];
            s_d.raw2 = ({s_q.u2_dl, s_q.u2_con[5:4]} != 10'h000);
        end else if (pwm2 && tick && {s_q.u2_dh, s_q.u2_lat} == cnt_nx) begin
            s_d.raw2 = 1'b0;
        end else if (!pwm2) begin
            s_d.raw2 = 1'b0;
        end
        // software writes
        if (wr) begin
            case (paddr)
                `CCPM_TMR_OFF: s_d.tmr = wb;
                `CCPM_PR_OFF: s_d.pr = wb;
                `CCPM_PERIOD_TIMER_CONTROL_OFF: s_d.period_timer_control = wb[6:0];
                `CCPM_U1_DL_OFF: s_d.u1_dl = wb;
                `CCPM_U1_DH_OFF: s_d.u1_dh = pwm1 ? s_q.u1_dh : wb;
                `CCPM_U1_CON_OFF: s_d.u1_con = LARGE_PKG ? wb : {2'h0, wb[5:0]};
                `CCPM_U2_DL_OFF: s_d.u2_dl = wb;
                `CCPM_U2_DH_OFF: s_d.u2_dh = pwm2 ? s_q.u2_dh : wb;
                `CCPM_U2_CON_OFF: s_d.u2_con = wb[5:0];
                `CCPM_AS_OFF: s_d.as_ctl = LARGE_PKG ? wb : {wb[7:2], 2'h0};
                `CCPM_DB_OFF: s_d.db_ctl = LARGE_PKG ? wb : {wb[7], 7'h00};
                default: s_d.tmr = s_d.tmr;
            endcase
        end
        // off and reserved modes drop the output at the edge that selects them
        if (s_d.u1_con[3:1] == 3'h0) begin
            s_d.raw1 = 1'b0;
        end
        // shutdown event and sticky flag: a set wins over a clear
        if (fault_in && s_q.as_ctl[6:4] != 3'h0) begin
            s_d.as_ctl[`CCPM_SD_STAT_BIT] = 1'b1;
        end
        s_d.flag = (s_q.flag && !clr_flag) || set_flag;
        // output steering from the next state so pins and control stay in step
        if (s_d.u1_con[3:2] == 2'h3) begin
            cfg = LARGE_PKG ? s_d.u1_con[7:6] : 2'h0;
            case (cfg)
                CCPM_SINGLE: begin
                    lvl = {3'h0, s_d.raw1};
                    en = 4'h1;
                end
                CCPM_FWD: begin
                    lvl = {s_d.raw1, 1'b0, 1'b0, 1'b1};
                    en = 4'hf;
                end
                CCPM_HALF: begin
                    lvl = {2'h0, !s_d.raw1 && s_d.dead == 7'h00, s_d.raw1 && s_d.dead == 7'h00};
                    en = 4'h3;
                end
                default: begin
                    lvl = {1'b0, 1'b1, s_d.raw1, 1'b0};
                    en = 4'hf;
                end
            endcase
            lvl = lvl ^ {s_d.u1_con[0], s_d.u1_con[1], s_d.u1_con[0], s_d.u1_con[1]};
            if (s_d.as_ctl[`CCPM_SD_STAT_BIT]) begin
                lvl = {s_d.as_ctl[0], s_d.as_ctl[2], s_d.as_ctl[0], s_d.as_ctl[2]};
                en = en & {!s_d.as_ctl[1], !s_d.as_ctl[3], !s_d.as_ctl[1], !s_d.as_ctl[3]};
            end
        end else if (s_d.u1_con[3:0] == CCPM_CMP_TGL || s_d.u1_con[3:1] == 3'h4) begin
            lvl = {3'h0, s_d.raw1};
            en = 4'h1;
        end
        s_d.pin = lvl & en;
        s_d.oe = en;
        s_d.u2_out = s_d.raw2;
        s_d.u2_oe = (s_d.u2_con[3:2] == 2'h3);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.pr <= `CCPM_PR_RST;
            s_q.u1_con <= `CCPM_CON_RST;
            s_q.as_ctl <= `CCPM_ZERO_RST;
            s_q.db_ctl <= `CCPM_ZERO_RST;
        end else if (pclk_en) begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} = s_q.pin;
    assign {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} = s_q.oe;
    assign unit_two_out = s_q.u2_out;
    assign unit_two_oe = s_q.u2_oe;
    assign unit_one_event_flag = s_q.flag;
    assign special_event_reset = s_q.special;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_read_ctl_s;
        pclk_en && setup && !pwrite && paddr == `CCPM_U1_CON_OFF;
    endsequence

    ctl_readback_a: assert property (apb_read_ctl_s |=> prdata[7:0] == $past(s_q.u1_con) && pready)
        else $error("control register readback mismatch");
    small_pkg_bits_a: assert property (!LARGE_PKG |-> s_q.u1_con[7:6] == 2'h0 &&
        s_q.db_ctl[6:0] == 7'h00 && s_q.as_ctl[1:0] == 2'h0)
        else $error("enhanced bits set on small package");
    non_pwm_pins_a: assert property (s_q.u1_con[3:2] != 2'h3 |-> !pwm_oe_b && !pwm_oe_c && !pwm_oe_d)
        else $error("b/c/d driven outside pwm");
    single_out_a: assert property (pwm1 && s_q.u1_con[7:6] == 2'h0 && !s_q.as_ctl[7] |->
        pwm_oe_a && !pwm_oe_b && !pwm_oe_c && !pwm_oe_d)
        else $error("single output drives extra pins");
    fwd_bridge_a: assert property (LARGE_PKG && pwm1 && s_q.u1_con[7:6] == 2'h1 && !s_q.as_ctl[7] |->
        pwm_out_a == !s_q.u1_con[1] && pwm_out_b == s_q.u1_con[0] && pwm_out_c == s_q.u1_con[1])
        else $error("forward bridge levels wrong");
    rev_bridge_a: assert property (LARGE_PKG && pwm1 && s_q.u1_con[7:6] == 2'h3 && !s_q.as_ctl[7] |->
        pwm_out_c == !s_q.u1_con[1] && pwm_out_a == s_q.u1_con[1] && pwm_out_d == s_q.u1_con[0])
        else $error("reverse bridge levels wrong");
    period_wrap_a: assert property (pclk_en && wrap && pwm1 && !wr |=>
        s_q.tmr == 8'h00 && s_q.u1_dh == $past(s_q.u1_dl))
        else $error("period end did not clear timer or latch duty");
    duty_clear_a: assert property (pclk_en && pwm1 && tick && !wrap &&
        {s_q.u1_dh, s_q.u1_lat} == cnt_nx |=> !s_q.raw1)
        else $error("duty match did not clear output");
    special_event_a: assert property (pclk_en && s_q.u1_con[3:0] == CCPM_CMP_SPEC && cmp_rise |=>
        special_event_reset && unit_one_event_flag ##1 !special_event_reset || !pclk_en)
        else $error("special event pulse or flag missing");
    off_state_a: assert property (s_q.u1_con[3:1] == 3'h0 |-> !pwm_oe_a && !s_q.raw1)
        else $error("off mode still drives output");
endmodule

// >>> verif/ccpm_load_model.sv
// load model for the unit's pins: pull-down on each pin, high-time counters
// assumes drive and enable in order a, b, c, d, unit two, all on clk
`timescale 1ns/1ps
module ccpm_load_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic [4:0] drive,
    input wire logic [4:0] enable,
    output logic [4:0] level,
    output logic [39:0] high_cnt
);
    // an undriven pin is a port pin held low by the pull-down
    assign level = drive & enable;
    always_ff @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (clr) begin
                high_cnt[8*i +: 8] <= 8'h00;
            end else begin
                high_cnt[8*i +: 8] <= high_cnt[8*i +: 8] + {7'h00, level[i]};
            end
        end
    end
endmodule

// >>> verif/tb_capture_compare_pwm_mode_control.sv
// self-checking bench for the ccp/pwm unit: apb master, compare/capture stimulus, pin load
// assumes ccpm_top with zero-wait apb and ccpm_load_model on its pins
`timescale 1ns/1ps
module tb_capture_compare_pwm_mode_control;
    logic pclk, presetn, psel, penable, pwrite, cap_in, fault, clr, err, pready, pslverr;
    logic u2o, u2oe, flag, ser;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, prdata_s, rds;
    logic [15:0] ctv;
    logic [3:0] po, poe;
    logic [4:0] lvl;
    logic [39:0] hc;
    int mismatches, check_count;
    localparam int ROLE [4][4] = '{'{1, 0, 0, 0}, '{2, 3, 3, 1}, '{1, 4, 0, 0}, '{3, 1, 2, 3}};
    localparam logic [3:0] OE [4] = '{4'h1, 4'hf, 4'h3, 4'hf};
    localparam logic [7:0] DH [3] = '{8'h00, 8'h03, 8'h04};
    localparam logic [1:0] DB [3] = '{2'h0, 2'h3, 2'h0};
    localparam int DX [3] = '{0, 60, 64};

    ccpm_top #(.LARGE_PKG(1'b1)) u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_in(cap_in), .capture_timer_val(ctv),
        .fault_in(fault), .pwm_out_a(po[0]), .pwm_out_b(po[1]), .pwm_out_c(po[2]), .pwm_out_d(po[3]),
        .pwm_oe_a(poe[0]), .pwm_oe_b(poe[1]), .pwm_oe_c(poe[2]), .pwm_oe_d(poe[3]),
        .unit_two_out(u2o), .unit_two_oe(u2oe), .unit_one_event_flag(flag), .special_event_reset(ser));
    ccpm_load_model u_load (.clk(pclk), .clr(clr), .drive({u2o, po}), .enable({u2oe, poe}),
        .level(lvl), .high_cnt(hc));
    // small package variant on the same bus, read back only
    ccpm_top #(.LARGE_PKG(1'b0)) u_small (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s),
        .pready(), .pslverr(), .capture_in(cap_in), .capture_timer_val(ctv),
        .fault_in(fault), .pwm_out_a(), .pwm_out_b(), .pwm_out_c(), .pwm_out_d(),
        .pwm_oe_a(), .pwm_oe_b(), .pwm_oe_c(), .pwm_oe_d(),
        .unit_two_out(), .unit_two_oe(), .unit_one_event_flag(), .special_event_reset());

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic final_report;
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            mismatches++;
            final_report();
        end
        rd = prdata;
        rds = prdata_s;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // settle 40 cycles, then count high cycles of every pin over 64 cycles
    task automatic cnt64;
        repeat (40) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (64) @(posedge pclk);
        @(negedge pclk);
    endtask

    function automatic int exp_cnt(input int cfg, input int pin, input logic [1:0] pol);
        logic p;
        p = pin[0] ? pol[0] : pol[1];
        case (ROLE[cfg][pin])
            1: return p ? 40 : 24;
            2: return p ? 0 : 64;
            3: return p ? 64 : 0;
            4: return p ? 24 : 40;
            default: return 0;
        endcase
    endfunction

    task automatic t_regs;
        apb(8'h14, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h04, 1'b0, 32'h0);
        chk(rd, 32'hff);
        apb(8'h14, 1'b1, 32'ha5);
        apb(8'h14, 1'b0, 32'h0);
        chk(rd, 32'ha5);
        chk(rds, 32'h25);
        apb(8'h28, 1'b1, 32'h85);
        apb(8'h28, 1'b0, 32'h0);
        chk(rd, 32'h85);
        chk(rds, 32'h80);
        apb(8'h28, 1'b1, 32'h0);
        apb(8'h14, 1'b1, 32'h0);
        apb(8'h30, 1'b0, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
    endtask

    task automatic t_pwm;
        apb(8'h04, 1'b1, 32'h03);
        apb(8'h0c, 1'b1, 32'h01);
        apb(8'h08, 1'b1, 32'h04);
        for (int cfg = 0; cfg < 4; cfg++) begin
            for (int pol = 0; pol < 4; pol++) begin
                apb(8'h14, 1'b1, {24'h0, cfg[1:0], 2'b10, 2'b11, pol[1:0]});
                cnt64();
                chk(32'(poe), 32'(OE[cfg]));
                for (int pin = 0; pin < 4; pin++) begin
                    chk(32'(hc[8*pin +: 8]), 32'(exp_cnt(cfg, pin, pol[1:0])));
                end
            end
        end
    endtask

    task automatic t_duty;
        for (int i = 0; i < 3; i++) begin
            apb(8'h0c, 1'b1, {24'h0, DH[i]});
            apb(8'h14, 1'b1, {26'h0, DB[i], 4'hc});
            cnt64();
            chk(32'(hc[7:0]), 32'(DX[i]));
        end
        // half bridge, duty 6 of 16, dead-band 2 cycles on each edge
        apb(8'h28, 1'b1, 32'h02);
        apb(8'h0c, 1'b1, 32'h01);
        apb(8'h14, 1'b1, 32'hac);
        cnt64();
        chk(32'(hc[7:0]), 32'd16);
        chk(32'(hc[15:8]), 32'd32);
        // prescale by 4: one period fills the 64-cycle window
        apb(8'h28, 1'b1, 32'h00);
        apb(8'h14, 1'b1, 32'h2c);
        apb(8'h08, 1'b1, 32'h05);
        cnt64();
        cnt64();
        chk(32'(hc[7:0]), 32'd24);
        apb(8'h08, 1'b1, 32'h04);
        apb(8'h14, 1'b1, 32'h0);
    endtask

    task automatic t_cmp(input logic [3:0] m, input logic ei, input logic ea, input logic ef);
        logic p0;
        int n;
        n = 0;
        apb(8'h10, 1'b1, 32'h12);
        apb(8'h0c, 1'b1, 32'h34);
        apb(8'h14, 1'b1, {24'h0, 4'hc, m});
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        p0 = lvl[0];
        chk(32'(poe[3:1]), 32'h0);
        if (m != 4'h2) chk(32'(p0), 32'(ei));
        @(posedge pclk);
        ctv <= 16'h1234;
        for (int i = 0; i < 6; i++) begin
            @(posedge pclk);
            if (ser === 1'b1) n++;
        end
        @(negedge pclk);
        chk(32'(flag), 32'(ef));
        chk(32'(lvl[0]), 32'((m == 4'h2) ? !p0 : ea));
        chk(32'(n), 32'(m == 4'hb));
        chk(32'(poe[0]), 32'(m == 4'h2 || m == 4'h8 || m == 4'h9));
        ctv <= 16'h0;
        apb(8'h2c, 1'b1, 32'h1);
        apb(8'h14, 1'b1, 32'h0);
        @(negedge pclk);
        chk(32'(flag), 32'h0);
    endtask

    task automatic t_cap(input logic [3:0] m, input int n, input logic fall);
        apb(8'h14, 1'b1, {28'h0, m});
        ctv <= 16'h5a3c;
        for (int k = 1; k <= n; k++) begin
            @(posedge pclk);
            cap_in <= 1'b1;
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk(32'(flag), 32'(!fall && k == n));
            @(posedge pclk);
            cap_in <= 1'b0;
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk(32'(flag), 32'(k == n));
        end
        apb(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h5a);
        apb(8'h0c, 1'b0, 32'h0);
        chk(rd, 32'h3c);
        ctv <= 16'h0;
        apb(8'h2c, 1'b1, 32'h1);
        apb(8'h14, 1'b1, 32'h0);
    endtask

    task automatic t_shut;
        apb(8'h0c, 1'b1, 32'hff);
        apb(8'h14, 1'b1, 32'h0c);
        apb(8'h18, 1'b1, 32'hff);
        apb(8'h20, 1'b1, 32'h0c);
        apb(8'h24, 1'b1, 32'h10);
        fault <= 1'b1;
        cnt64();
        chk(32'(hc[7:0]), 32'h0);
        chk(32'(hc[39:32]), 32'd64);
        chk(32'(u2oe), 32'h1);
        apb(8'h24, 1'b0, 32'h0);
        chk(rd, 32'h90);
        chk(rds, 32'h90);
        fault <= 1'b0;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cap_in = 1'b0;
        fault = 1'b0;
        clr = 1'b0;
        ctv = 16'h0;
        mismatches = 0;
        check_count = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pwm();
        t_duty();
        t_cmp(4'h0, 1'b0, 1'b0, 1'b0);
        t_cmp(4'h1, 1'b0, 1'b0, 1'b0);
        t_cmp(4'h2, 1'b0, 1'b0, 1'b1);
        t_cmp(4'h8, 1'b0, 1'b1, 1'b1);
        t_cmp(4'h9, 1'b1, 1'b0, 1'b1);
        t_cmp(4'ha, 1'b0, 1'b0, 1'b1);
        t_cmp(4'hb, 1'b0, 1'b0, 1'b1);
        t_cap(4'h3, 1, 1'b0);
        t_cap(4'h4, 1, 1'b1);
        t_cap(4'h5, 1, 1'b0);
        t_cap(4'h6, 4, 1'b0);
        t_cap(4'h7, 16, 1'b0);
        t_shut();
        final_report();
    end
endmodule
